// ==== verilog/asc_pkg.sv ====
`default_nettype none
// ==========================================================
// shared constants for the serial config and readout block
package asc_pkg;
  // command field codes
  localparam logic [3:0] CMD_CH_LAST = 4'h7;
  localparam logic [3:0] CMD_WAKE    = 4'hB;
  localparam logic [3:0] CMD_RD_CFG  = 4'hC;
  localparam logic [3:0] CMD_RD_DATA = 4'hD;
  localparam logic [3:0] CMD_WR_CFG  = 4'hE;
  localparam logic [3:0] CMD_DEFAULT = 4'hF;
  // configuration word value after any reset
  localparam logic [11:0] CFG_RESET = 12'hFFF;
  // configuration word field positions
  localparam int CFG_AUTO_CH  = 11;
  localparam int CFG_OSC      = 10;
  localparam int CFG_MANUAL   = 9;
  localparam int CFG_SLOW     = 8;
  localparam int CFG_POL_LOW  = 7;
  localparam int CFG_EOC_FN   = 6;
  localparam int CFG_NO_CHAIN = 5;
  localparam int CFG_NO_ANAP  = 4;
  localparam int CFG_NO_NAP   = 3;
  localparam int CFG_NO_DEEP  = 2;
  localparam int CFG_TAG      = 1;
  localparam int CFG_NO_SWRST = 0;
  // serial edge counts (last edge index of a field, zero based)
  localparam logic [4:0] EDGE_CMD_LAST  = 5'h03;
  localparam logic [4:0] EDGE_WORD_LAST = 5'h0F;
  localparam logic [4:0] EDGE_CNT_MAX   = 5'h1F;
  localparam logic [4:0] OWN_LEN_PLAIN  = 5'h10;
  localparam logic [4:0] OWN_LEN_TAG    = 5'h18;
  // conversion clock counts
  localparam logic [5:0] SAMPLE_CCLKS   = 6'h03;
  localparam logic [5:0] CONV_CCLKS     = 6'h12;
  localparam logic [5:0] ANAP_CCLKS     = 6'h06;
  localparam logic [5:0] SLOW_GAP_CCLKS = 6'h15;
  // internal oscillator divide from the system clock
  localparam int OSC_DIV_CYCLES = 6;
  // synchroniser reset values: fs, conversion_start_pin, reset pin idle high
  localparam logic [5:0] SYNC_RST = 6'h07;
  // conversion engine states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONV,
    ST_GAP
  } asc_state_type;
endpackage
`default_nettype wire

// ==== verilog/asc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two flip-flop synchroniser, one bit per lane
module asc_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta <= RST;
      q_o  <= RST;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // asc_sync
`default_nettype wire

// ==== verilog/asc_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// tick generator standing in for the internal oscillator
module asc_divider #(
  parameter int DIV = 6
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  output logic      tick_o
);
  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt;

  // one pulse every DIV system clocks
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt == LAST);
      cnt    <= (cnt == LAST) ? '0 : cnt + CW'(1);
    end
  end
endmodule // asc_divider
`default_nettype wire

// ==== verilog/asc_serial_config.sv ====
`timescale 1ns/1ps
`default_nettype none
// Function
// - four-bit commands take effect at the fourth falling serial edge
// - code 1110 plus 12 data bits loads configuration at edge sixteen
// - command 1111 and every reset load all-ones configuration
// - command 1100 returns four result MSBs then the configuration word
// - bit 11 picks manual channel commands or automatic channel sequence
// - bit 10 picks half serial clock or internal oscillator as conversion clock
// - bit 8 sets automatic period of 21 or 42 conversion clocks
// - bit 7 sets status output polarity, high or low active
// - bit 6 picks attention or conversion-done function of status pin
// - bit 5 low turns status pin into chain data input
// - bit 4 low enables automatic doze, ignored when bits 9 and 8 low
// - bits 3 and 2 low power down; wake-up sets them again
// - bit 1 appends three channel bits after result; host gives 19 clocks
// - writing zero to bit 0 resets device; bit returns to one
// - done result enters output register, shown from next frame start
// - frame before conversion end reads previous, after reads current result
// - result is 16-bit straight binary MSB first, then tags, then zeros
// - serial data out driven only while frame select low
// - output follows supplied clocks; first frame after reset is all ones
// - command codes 0-7 channels, B wake, D read; 8 to A reserved
// - frame starts at frame select fall; data moves on falling edges
// - chain mode passes chain input after 16 or 24 clocks
module asc_serial_config
  import asc_pkg::*;
#(
  parameter int NUM_CH  = 8,
  parameter int OSC_DIV = OSC_DIV_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        sclk_i,
  input  wire logic        fs_n_i,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  input  wire logic        conversion_start_pin_n_i,
  input  wire logic        rst_n_i,
  input  wire logic        status_i,
  output logic             status_o,
  output logic             status_oe_o,
  input  wire logic [15:0] conv_result_i,
  output logic      [2:0]  channel_o,
  output logic             sampling_o,
  output logic             converting_o,
  output logic             nap_o,
  output logic             deep_pd_o,
  output logic      [11:0] configuration_word_o
);
  // ==========================================================
  // link domain state (falling serial clock)
  logic [4:0]  bit_cnt;
  logic        rd_cfg;
  logic [15:0] rx_sh;
  logic [23:0] chain_sh;
  logic [3:0]  cmd_hold;
  logic [15:0] word_hold;
  logic        cmd_tgl;
  logic        word_tgl;
  logic        sclk_tgl;
  logic [3:0]  next_cmd;
  logic [15:0] next_word;
  logic [31:0] own_word;
  logic [4:0]  own_len;
  // frame snapshot, held stable while frame select is low
  logic [15:0] frame_res;
  logic [2:0]  frame_tag;
  logic [11:0] frame_cfg;
  logic        frame_ones;
  // system domain state
  logic [5:0]  sync_q;
  logic        fs_s;
  logic        conversion_start_pin_s;
  logic        rstpin_s;
  logic        fs_d;
  logic        conversion_start_pin_d;
  logic        cmd_seen;
  logic        word_seen;
  logic        sclk_seen;
  logic        fs_fall;
  logic        conversion_start_pin_fall;
  logic        cmd_evt;
  logic        word_evt;
  logic        sclk_evt;
  logic [11:0] configuration_word;
  logic        sw_rst;
  logic        dev_rst;
  logic        first_frame;
  logic        osc_tick;
  logic        sclk_half;
  logic        conversion_clock_tick;
  asc_state_type state;
  logic [5:0]  cc;
  logic [5:0]  conv_len;
  logic [2:0]  chan;
  logic [15:0] res_q;
  logic [2:0]  tag_q;
  logic        int_flag;
  logic        status_act;
  logic        pd;
  logic        manual;
  logic        conv_done;

  assign next_cmd  = {rx_sh[2:0], sdi_i};
  assign next_word = {rx_sh[14:0], sdi_i};

  // ==========================================================
  // link: edge count, restarted by every frame select rise
  // frame start
  always_ff @(negedge sclk_i or posedge fs_n_i) begin
    if (fs_n_i) begin
      bit_cnt <= 5'h00;
      rd_cfg  <= 1'b0;
    end else begin
      if (bit_cnt != EDGE_CNT_MAX) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      if (bit_cnt == EDGE_CMD_LAST) begin
        rd_cfg <= (next_cmd == CMD_RD_CFG);
      end
    end
  end

  // link: input shifting and event toggles toward system clock
  always_ff @(negedge sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_sh     <= 16'h0000;
      chain_sh  <= 24'h00_0000;
      cmd_hold  <= 4'h0;
      word_hold <= 16'h0000;
      cmd_tgl   <= 1'b0;
      word_tgl  <= 1'b0;
      sclk_tgl  <= 1'b0;
    end else begin
      rx_sh    <= next_word;
      chain_sh <= {chain_sh[22:0], status_i};
      sclk_tgl <= ~sclk_tgl;
      if (bit_cnt == EDGE_CMD_LAST) begin
        cmd_hold <= next_cmd;
        cmd_tgl  <= ~cmd_tgl;
      end
      if (bit_cnt == EDGE_WORD_LAST) begin
        word_hold <= next_word;
        word_tgl  <= ~word_tgl;
      end
    end
  end

  // link: output bit chosen from the frame snapshot
  assign own_len  = frame_cfg[CFG_TAG] ? OWN_LEN_TAG : OWN_LEN_PLAIN;
  // msb first then tags then zeros
  assign own_word = {rd_cfg ? {frame_res[15:12], frame_cfg} : frame_res,
                     frame_cfg[CFG_TAG] ? frame_tag : 3'h0, 13'h0000};
  always_comb begin
    if (frame_ones) begin
      sdo_o = 1'b1;
    end else if (!frame_cfg[CFG_NO_CHAIN] && bit_cnt >= own_len) begin
      sdo_o = chain_sh[5'(own_len - 5'h01)];
    end else begin
      sdo_o = own_word[5'(EDGE_CNT_MAX - bit_cnt)];
    end
  end
  assign sdo_oe_o = ~fs_n_i;

  // ==========================================================
  // crossings into the system clock
  asc_sync #(
    .W   (6),
    .RST (SYNC_RST)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({sclk_tgl, word_tgl, cmd_tgl, rst_n_i, conversion_start_pin_n_i,
                 fs_n_i}),
    .q_o       (sync_q)
  );
  assign fs_s     = sync_q[0];
  assign conversion_start_pin_s = sync_q[1];
  assign rstpin_s = sync_q[2];

  // edge and toggle detection on synchronised levels
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fs_d      <= 1'b1;
      conversion_start_pin_d  <= 1'b1;
      cmd_seen  <= 1'b0;
      word_seen <= 1'b0;
      sclk_seen <= 1'b0;
    end else begin
      fs_d      <= fs_s;
      conversion_start_pin_d  <= conversion_start_pin_s;
      cmd_seen  <= sync_q[3];
      word_seen <= sync_q[4];
      sclk_seen <= sync_q[5];
    end
  end
  assign fs_fall     = fs_d & ~fs_s;
  assign conversion_start_pin_fall = conversion_start_pin_d & ~conversion_start_pin_s;
  assign cmd_evt     = cmd_seen ^ sync_q[3];
  assign word_evt    = word_seen ^ sync_q[4];
  assign sclk_evt    = sclk_seen ^ sync_q[5];

  // ==========================================================
  // configuration word and resets
  // all sources of reset
  assign dev_rst = sys_rst_i | ~rstpin_s | sw_rst;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sw_rst <= 1'b0;
    end else begin
      sw_rst <= word_evt && word_hold[15:12] == CMD_WR_CFG &&
                !word_hold[CFG_NO_SWRST];
    end
  end

  // command decode, reserved codes fall through
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      configuration_word <= CFG_RESET;
    end else if (cmd_evt && cmd_hold == CMD_DEFAULT) begin
      configuration_word <= CFG_RESET;
    end else if (cmd_evt && cmd_hold == CMD_WAKE) begin
      configuration_word[CFG_NO_NAP]  <= 1'b1;
      configuration_word[CFG_NO_DEEP] <= 1'b1;
    end else if (word_evt && word_hold[15:12] == CMD_WR_CFG) begin
      configuration_word <= word_hold[11:0];
    end
  end
  assign configuration_word_o = configuration_word;

  // ==========================================================
  // conversion clock source
  asc_divider #(
    .DIV (OSC_DIV)
  ) u_osc (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_o    (osc_tick)
  );

  // half rate tick from serial clock edges
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sclk_half <= 1'b0;
    end else if (sclk_evt) begin
      sclk_half <= ~sclk_half;
    end
  end
  assign conversion_clock_tick = configuration_word[CFG_OSC] ? osc_tick
                                                  : (sclk_evt & sclk_half);

  // ==========================================================
  // conversion engine
  // power down levels
  assign pd     = ~configuration_word[CFG_NO_NAP] |
                  ~configuration_word[CFG_NO_DEEP];
  assign manual = configuration_word[CFG_MANUAL];
  // auto doze lengthens conversion unless bits 9 and 8 low
  assign conv_len = (!configuration_word[CFG_NO_ANAP] &&
                     (configuration_word[CFG_MANUAL] ||
                      configuration_word[CFG_SLOW]))
                    ? CONV_CCLKS + ANAP_CCLKS : CONV_CCLKS;
  assign conv_done = (state == ST_CONV) && conversion_clock_tick &&
                     (cc == conv_len - 6'h01);

  // sample, convert and period timing
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      state <= ST_SAMPLE;
      cc    <= 6'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (!pd) begin
            state <= ST_SAMPLE;
            cc    <= 6'h00;
          end
        end
        ST_SAMPLE: begin
          if (pd) begin
            state <= ST_IDLE;
          end else if (manual) begin
            if (conversion_start_pin_fall) begin
              state <= ST_CONV;
              cc    <= 6'h00;
            end
          // auto start three clocks into sampling
          end else if (conversion_clock_tick) begin
            if (cc == SAMPLE_CCLKS - 6'h01) begin
              state <= ST_CONV;
              cc    <= 6'h00;
            end else begin
              cc <= cc + 6'h01;
            end
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            state <= (!manual && configuration_word[CFG_SLOW])
                     ? ST_GAP : ST_SAMPLE;
            cc    <= 6'h00;
          end else if (conversion_clock_tick) begin
            cc <= cc + 6'h01;
          end
        end
        ST_GAP: begin
          if (conversion_clock_tick) begin
            if (cc == SLOW_GAP_CCLKS - 6'h01) begin
              state <= ST_SAMPLE;
              cc    <= 6'h00;
            end else begin
              cc <= cc + 6'h01;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          cc    <= 6'h00;
        end
      endcase
    end
  end

  // channel selection, manual command or automatic sequence
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      chan <= 3'h0;
    end else if (configuration_word[CFG_AUTO_CH]) begin
      if (conv_done) begin
        chan <= (32'(chan) == NUM_CH - 1) ? 3'h0 : chan + 3'h1;
      end
    end else if (cmd_evt && cmd_hold <= CMD_CH_LAST &&
                 32'(cmd_hold) < NUM_CH) begin
      chan <= cmd_hold[2:0];
    end
  end

  // result into output register at done
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      res_q <= 16'h0000;
      tag_q <= 3'h0;
    end else if (conv_done) begin
      res_q <= conv_result_i;
      tag_q <= chan;
    end
  end

  // frame snapshot at frame select fall
  // previous or current result by frame start time
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      frame_res   <= 16'h0000;
      frame_tag   <= 3'h0;
      frame_cfg   <= CFG_RESET;
      frame_ones  <= 1'b0;
      first_frame <= 1'b1;
    end else if (fs_fall) begin
      frame_res   <= res_q;
      frame_tag   <= tag_q;
      frame_cfg   <= configuration_word;
      frame_ones  <= first_frame;
      first_frame <= 1'b0;
    end
  end

  // ==========================================================
  // status pin: attention flag, done level, polarity, direction
  // configuration readback frames leave the attention flag alone
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      int_flag <= 1'b0;
    end else if (conv_done) begin
      int_flag <= 1'b1;
    end else if (cmd_evt && cmd_hold != CMD_RD_CFG) begin
      int_flag <= 1'b0;
    end
  end
  assign status_act = configuration_word[CFG_EOC_FN] ? (state != ST_CONV)
                                                     : int_flag;
  assign status_o    = status_act ^ configuration_word[CFG_POL_LOW];
  assign status_oe_o = configuration_word[CFG_NO_CHAIN];

  // analog core controls
  assign channel_o    = chan;
  assign sampling_o   = (state == ST_SAMPLE);
  assign converting_o = (state == ST_CONV);
  assign nap_o        = ~configuration_word[CFG_NO_NAP];
  assign deep_pd_o    = ~configuration_word[CFG_NO_DEEP];
endmodule // asc_serial_config
`default_nettype wire

// ==== verif/asc_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port level checks for the serial config block
module asc_assertions
  import asc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        fs_n_i,
  input wire logic        rst_n_i,
  input wire logic        sdo_oe_o,
  input wire logic        status_o,
  input wire logic        status_oe_o,
  input wire logic        converting_o,
  input wire logic [2:0]  channel_o,
  input wire logic        nap_o,
  input wire logic        deep_pd_o,
  input wire logic [11:0] configuration_word_o
);
  logic [3:0] idle_cnt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // cycles since frame select or reset pin was last low
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !fs_n_i || !rst_n_i) begin
      idle_cnt <= 4'h0;
    end else if (idle_cnt != 4'hF) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  // ==========================================================
  // properties
  a_oe_tracks_fs: assert property (
    sdo_oe_o == !fs_n_i)
    else $error("data out enable differs from frame select");
  a_status_dir: assert property (
    status_oe_o == configuration_word_o[CFG_NO_CHAIN])
    else $error("status pin direction wrong");
  a_power_levels: assert property (
    nap_o == !configuration_word_o[CFG_NO_NAP] &&
    deep_pd_o == !configuration_word_o[CFG_NO_DEEP])
    else $error("power down levels wrong");
  a_done_polarity: assert property (
    configuration_word_o[CFG_EOC_FN] && configuration_word_o[CFG_NO_CHAIN]
    |-> status_o == (!converting_o ^ configuration_word_o[CFG_POL_LOW]))
    else $error("done flag level or polarity wrong");
  a_reset_default: assert property (
    $fell(sys_rst_i) |-> configuration_word_o == CFG_RESET)
    else $error("configuration not all ones after reset");
  a_pin_reset: assert property (
    $fell(rst_n_i) |-> ##[1:6] configuration_word_o == CFG_RESET)
    else $error("reset pin did not restore configuration");
  a_swrst_return: assert property (
    !configuration_word_o[CFG_NO_SWRST]
    |-> ##[1:8] configuration_word_o == CFG_RESET)
    else $error("software reset did not restore configuration");
  a_cfg_quiet: assert property (
    idle_cnt == 4'hF |-> $stable(configuration_word_o))
    else $error("configuration changed outside a frame");
  a_channel_quiet: assert property (
    idle_cnt == 4'hF && !configuration_word_o[CFG_AUTO_CH]
    |-> $stable(channel_o))
    else $error("manual channel changed without a command");
endmodule // asc_assertions

bind asc_serial_config asc_assertions u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .fs_n_i(fs_n_i),
  .rst_n_i(rst_n_i), .sdo_oe_o(sdo_oe_o), .status_o(status_o),
  .status_oe_o(status_oe_o), .converting_o(converting_o),
  .channel_o(channel_o), .nap_o(nap_o), .deep_pd_o(deep_pd_o),
  .configuration_word_o(configuration_word_o)
);
`default_nettype wire

// ==== verif/asc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host serial master: frame select, serial clock, data in
module asc_host_model (
  output logic      sclk_o,
  output logic      fs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  // clock idles high and stands still between frames
  initial begin
    sclk_o = 1'b1;
    fs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // shift n bits msb first, collect data out into rx
  task automatic xfer(input logic [23:0] tx, input int n,
                      output logic [23:0] rx);
    rx = 24'h00_0000;
    fs_n_o = 1'b0;
    #62.5;
    for (int k = 0; k < n; k++) begin
      sdi_o = tx[n-1-k];
      #31.25;
      rx = {rx[22:0], sdo_i};
      sclk_o = 1'b0;
      #62.5;
      sclk_o = 1'b1;
      #31.25;
    end
    fs_n_o = 1'b1;
    // released data line shows the inverse of its last value
    sdi_o = ~sdi_o;
    #250;
  endtask
endmodule // asc_host_model
`default_nettype wire

// ==== verif/adc_serial_config_readout_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the serial config block
module adc_serial_config_readout_tb_top;
  logic        clk_i;
  logic        sys_rst, sclk, fs_n, sdi, sdo, sdo_oe;
  logic        conversion_start_pin_n, rst_n, status, status_oe;
  logic        converting, nap, deep_pd, sampling, chain_in;
  logic [15:0] conv_result;
  logic [2:0]  channel;
  logic [11:0] cfg;
  int          bad_count = 0;
  int          compares = 0;

  asc_serial_config uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst), .sclk_i(sclk), .fs_n_i(fs_n),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .conversion_start_pin_n_i(conversion_start_pin_n),
    .rst_n_i(rst_n), .status_i(chain_in), .status_o(status),
    .status_oe_o(status_oe), .conv_result_i(conv_result),
    .channel_o(channel), .sampling_o(sampling), .converting_o(converting),
    .nap_o(nap), .deep_pd_o(deep_pd), .configuration_word_o(cfg)
  );
  asc_host_model host (.sclk_o(sclk), .fs_n_o(fs_n), .sdi_o(sdi),
                       .sdo_i(sdo));

  // system clock, 8 ns period
  always #4 clk_i = ~clk_i;

  // ==========================================================
  // helpers
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cfg(input logic [11:0] exp);
    check({12'h000, cfg}, {12'h000, exp});
  endtask
  task automatic wr(input logic [15:0] w);
    logic [23:0] rx;
    host.xfer({8'h00, w}, 16, rx);
  endtask
  task automatic settle();
    // quiet 2 us after any reset
    repeat (260) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_conv(input logic lvl);
    int n;
    n = 0;
    while (converting !== lvl && n < 1000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check({23'h00_0000, converting}, {23'h00_0000, lvl});
  endtask
  task automatic convert(input logic [15:0] res);
    @(posedge clk_i);
    #1 conv_result = res;
    conversion_start_pin_n = 1'b0;
    check({23'h00_0000, sampling}, 24'h00_0001);
    wait_conv(1'b1);
    conversion_start_pin_n = 1'b1;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_first();
    logic [23:0] rx;
    host.xfer(24'h00_D000, 16, rx);
    check(rx, 24'h00_FFFF);
    chk_cfg(12'hFFF);
  endtask
  task automatic t_config();
    logic [23:0] rx;
    wr(16'hE67F);
    chk_cfg(12'h67F);
    host.xfer(24'h00_000E, 4, rx);
    chk_cfg(12'h67F);
    host.xfer(24'h00_C000, 16, rx);
    check(rx, 24'h00_067F);
  endtask
  task automatic t_channels();
    logic [23:0] rx;
    for (int c = 0; c < 11; c++) begin
      host.xfer(24'(c), 4, rx);
      if (c < 8) begin
        check({21'h00_0000, channel}, 24'(c));
      end else begin
        check({9'h000, channel, cfg}, 24'h00_767F);
      end
    end
  endtask
  task automatic t_convert();
    logic [23:0] rx;
    convert(16'hC35A);
    wait_conv(1'b0);
    host.xfer(24'hD0_0000, 24, rx);
    check(rx, {16'hC35A, 3'h7, 5'h00});
    convert(16'h0F0F);
    // keep clear of the sampling end
    #100;
    host.xfer(24'hD0_0000, 24, rx);
    check(rx, {16'hC35A, 3'h7, 5'h00});
    wait_conv(1'b0);
    host.xfer(24'hD0_0000, 24, rx);
    check(rx, {16'h0F0F, 3'h7, 5'h00});
  endtask
  task automatic t_modes();
    logic [23:0] rx;
    wr(16'hE653);
    chk_cfg(12'h653);
    host.xfer(24'h00_000B, 4, rx);
    chk_cfg(12'h65F);
    host.xfer(24'h00_000F, 4, rx);
    chk_cfg(12'hFFF);
    // chain mode: upstream ones follow the own 16-bit result
    wr(16'hE65D);
    chain_in = 1'b1;
    host.xfer(24'hD0_0000, 24, rx);
    check(rx, {16'h0F0F, 8'hFF});
  endtask
  task automatic t_sclk_conversion_clock();
    logic [23:0] rx;
    // conversion clock from the serial clock: stalls without frames
    wr(16'hE27F);
    convert(16'hA5A5);
    host.xfer(24'hD0_0000, 24, rx);
    check(rx, {16'h0F0F, 3'h7, 5'h00});
    check({23'h00_0000, converting}, 24'h00_0001);
    host.xfer(24'hD0_0000, 24, rx);
    check({23'h00_0000, converting}, 24'h00_0000);
    host.xfer(24'hD0_0000, 24, rx);
    check(rx, {16'hA5A5, 3'h7, 5'h00});
  endtask
  task automatic t_auto();
    logic [2:0] ch;
    int         n;
    // auto trigger, slow rate, auto channel sequence
    wr(16'hED7F);
    wait_conv(1'b0);
    wait_conv(1'b1);
    ch = channel;
    n = 0;
    while (converting === 1'b1 && n < 1000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check({21'h00_0000, channel}, {21'h00_0000, ch + 3'h1});
    while (converting !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(24'(n), 24'(42 * asc_pkg::OSC_DIV_CYCLES));
  endtask
  task automatic t_resets();
    logic [23:0] rx;
    wr(16'hE67E);
    chk_cfg(12'hFFF);
    settle();
    host.xfer(24'h00_D000, 16, rx);
    check(rx, 24'h00_FFFF);
    wr(16'hE67F);
    @(posedge clk_i);
    #1 rst_n = 1'b0;
    repeat (5) @(posedge clk_i);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk_i);
    chk_cfg(12'hFFF);
  endtask

  // ==========================================================
  // verdict and end of run
  task automatic summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk_i = 1'b0;
    sys_rst = 1'b0;
    conversion_start_pin_n = 1'b1;
    rst_n = 1'b1;
    chain_in = 1'b0;
    conv_result = 16'h0000;
    // clean rising edge so the link side async reset always fires
    #1 sys_rst = 1'b1;
    repeat (10) @(posedge clk_i);
    #1 sys_rst = 1'b0;
    settle();
    t_first();
    t_config();
    t_channels();
    t_convert();
    t_modes();
    t_sclk_conversion_clock();
    t_auto();
    t_resets();
    summarize();
  end

  // watchdog: run needs about 8500 cycles, allow about seven times that
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
endmodule // adc_serial_config_readout_tb_top
`default_nettype wire
